// ==== wdog_consts.svh ====
// offsets, service keys, reset values and timing counts of the windowed watchdog
`ifndef WDOG_CONSTS_SVH
`define WDOG_CONSTS_SVH

`define ADDR_W          8
`define OFF_SERVICE     8'h00
`define OFF_OPTION      8'h04
`define OFF_IRQ_STATUS  8'h08
`define OFF_IRQ_MASK    8'h0c
`define OFF_COUNT       8'h10
`define OFF_STATE       8'h14

`define SERVICE_KEY     8'hac
`define SERVICE_RD_ON   8'h9a
`define SERVICE_RD_OFF  8'h1a
`define OPTION_RESET    8'hff

`define IRQ_W           1
`define CNT_W           18

`define CLK_HZ          25000000
`define LS_HZ           15000
`define LS_HALF_CYC     (`CLK_HZ / (`LS_HZ * 2))
`define DIV_W           12

`endif

// ==== wdog_pkg.sv ====
// types shared by the windowed watchdog modules
package wdog_pkg;

    // option byte, bit 7 down to bit 0
    typedef struct packed {
        logic       interval_irq_opt;
        logic       window_period_sel_hi;
        logic       window_period_sel_lo;
        logic       count_enable;
        logic       overflow_sel_2;
        logic       overflow_sel_1;
        logic       overflow_sel_0;
        logic       standby_run_opt;
    } opt_t;

    // limits in half periods of the low-speed clock
    typedef struct packed {
        logic [17:0] overflow_at;
        logic [17:0] close_end;
        logic [17:0] irq_at;
    } win_t;

endpackage

// ==== half_tick_div.sv ====
// divider giving one pulse per half period of the low-speed clock
`timescale 1ns/1ps
`include "wdog_consts.svh"
module half_tick_div
    import wdog_pkg::*;
(
    input  wire logic clk_sys,
    input  wire logic reset,
    output logic      tick
);
    localparam logic [`DIV_W-1:0] LAST = `DIV_W'(`LS_HALF_CYC - 1);

    logic [`DIV_W-1:0] div_q;

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            div_q <= '0;
        end else if (div_q == LAST) begin
            div_q <= '0;
        end else begin
            div_q <= div_q + `DIV_W'(1);
        end
    end

    assign tick = (div_q == LAST);
endmodule

// ==== window_calc.sv ====
// overflow, closed-window and interval limits from the option byte
`timescale 1ns/1ps
`include "wdog_consts.svh"
module window_calc
    import wdog_pkg::*;
(
    input  opt_t opt,
    output win_t win
);
    logic [4:0]        exp_n;
    logic [`CNT_W-1:0] ovf_h;

    always_comb begin
        case ({opt.overflow_sel_2, opt.overflow_sel_1, opt.overflow_sel_0})
            3'h0:    exp_n = 5'h06;
            3'h1:    exp_n = 5'h07;
            3'h2:    exp_n = 5'h08;
            3'h3:    exp_n = 5'h09;
            3'h4:    exp_n = 5'h0b;
            3'h5:    exp_n = 5'h0d;
            3'h6:    exp_n = 5'h0e;
            default: exp_n = 5'h10;
        endcase
        ovf_h           = `CNT_W'(1) << (exp_n + 5'h01);
        win.overflow_at = ovf_h;
        win.irq_at      = ovf_h - (ovf_h >> 2) + `CNT_W'(1);
        win.close_end   = '0;
        // closed part is (1 - open fraction) of the overflow time
        if (opt.standby_run_opt) begin
            case ({opt.window_period_sel_hi, opt.window_period_sel_lo})
                2'h1:    win.close_end = ovf_h >> 1;
                2'h2:    win.close_end = ovf_h >> 2;
                default: win.close_end = '0;
            endcase
        end
    end
endmodule

// ==== wdog_top.sv ====
// windowed watchdog with interval interrupt behind a classic wishbone slave
//
// How it works
// - key write inside open window clears counter and restarts from zero
// - key write inside closed window raises internal reset
// - first service write after reset clears counter regardless of window
// - window period selected by option bits six and five
// - window code 01 is 50%, 10 is 75%, 11 is 100%, 00 prohibited
// - standby-run option bit zero clear forces a 100% open window
// - overflow code picks 2^6,7,8,9,11,13,14,16 low-speed clock periods
// - interval interrupt at 75% of overflow plus half low-speed period
// - interval option bit one enables interrupt, zero disables it
// - counter keeps running after interval interrupt until a key write
// - no key write before overflow raises internal reset
// - any non-key value written to service register raises internal reset
// - service register reads 9a or 1a by enable option, never the key
//
// Design decisions made here: the placing of the registers and register access over Wishbone.
`timescale 1ns/1ps
`include "wdog_consts.svh"
module wdog_top
    import wdog_pkg::*;
(
    input  wire logic              clk_sys,
    input  wire logic              reset,
    input  wire logic              wb_cyc_i,
    input  wire logic              wb_stb_i,
    input  wire logic              wb_we_i,
    input  wire logic [`ADDR_W-1:0] wb_adr_i,
    input  wire logic [3:0]        wb_sel_i,
    input  wire logic [31:0]       wb_dat_i,
    output logic [31:0]            wb_dat_o,
    output logic                   wb_ack_o,
    output logic                   interval_irq,
    output logic                   internal_reset
);
    ////////////////////////////////////////////////////////////////////////////
    logic                  ack_q;
    logic [31:0]           dat_q;
    opt_t                  opt_q;
    logic [`IRQ_W-1:0]     status_q;
    logic [`IRQ_W-1:0]     mask_q;
    logic [`CNT_W-1:0]     cnt_q;
    logic                  first_done_q;
    logic                  fired_q;
    logic                  tick;
    win_t                  win;
    logic                  acc;
    logic                  wr;
    logic                  rd;
    logic                  svc_wr;
    logic                  key_ok;
    logic                  run;
    logic                  win_open;
    logic                  irq_evt;
    logic                  ovf_evt;
    logic                  svc_clear;
    logic                  svc_fault;

    half_tick_div u_div (
        .clk_sys (clk_sys),
        .reset   (reset),
        .tick    (tick)
    );

    window_calc u_win (
        .opt (opt_q),
        .win (win)
    );

    ////////////////////////////////////////////////////////////////////////////
    // bus slave: one wait state, answer in the cycle after the request
    assign acc    = wb_cyc_i && wb_stb_i && !ack_q;
    assign wr     = acc && wb_we_i;
    assign rd     = acc && !wb_we_i;
    assign svc_wr = wr && (wb_adr_i == `OFF_SERVICE) && wb_sel_i[0];

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            ack_q <= 1'b0;
        end else begin
            ack_q <= acc;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            dat_q <= '0;
        end else if (rd) begin
            if (wb_adr_i == `OFF_SERVICE) begin
                dat_q <= {24'h0, opt_q.count_enable ? `SERVICE_RD_ON : `SERVICE_RD_OFF};
            end else if (wb_adr_i == `OFF_OPTION) begin
                dat_q <= {24'h0, opt_q};
            end else if (wb_adr_i == `OFF_IRQ_STATUS) begin
                dat_q <= {{(32 - `IRQ_W){1'b0}}, status_q};
            end else if (wb_adr_i == `OFF_IRQ_MASK) begin
                dat_q <= {{(32 - `IRQ_W){1'b0}}, mask_q};
            end else if (wb_adr_i == `OFF_COUNT) begin
                dat_q <= {{(32 - `CNT_W){1'b0}}, cnt_q};
            end else if (wb_adr_i == `OFF_STATE) begin
                dat_q <= {29'h0, fired_q, win_open, first_done_q};
            end else begin
                dat_q <= '0;
            end
        end
    end

    assign wb_ack_o = ack_q;
    assign wb_dat_o = dat_q;

    ////////////////////////////////////////////////////////////////////////////
    // option byte, frozen once the first service write has happened
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            opt_q <= opt_t'(`OPTION_RESET);
        end else if (wr && (wb_adr_i == `OFF_OPTION) && wb_sel_i[0] && !first_done_q) begin
            opt_q <= opt_t'(wb_dat_i[7:0]);
        end
    end

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            mask_q <= '0;
        end else if (wr && (wb_adr_i == `OFF_IRQ_MASK) && wb_sel_i[0]) begin
            mask_q <= wb_dat_i[`IRQ_W-1:0];
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // service and window checks
    assign run       = opt_q.count_enable && !fired_q;
    assign key_ok    = (wb_dat_i[7:0] == `SERVICE_KEY);
    assign win_open  = (cnt_q >= win.close_end);
    assign svc_clear = svc_wr && key_ok && (!first_done_q || win_open);
    assign svc_fault = svc_wr && (!key_ok || (first_done_q && !win_open));
    assign ovf_evt   = run && !svc_clear && (cnt_q >= win.overflow_at);
    assign irq_evt   = run && tick && opt_q.interval_irq_opt && (cnt_q == win.irq_at - `CNT_W'(1));

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            first_done_q <= 1'b0;
        end else if (svc_wr) begin
            first_done_q <= 1'b1;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            cnt_q <= '0;
        end else if (fired_q) begin
            cnt_q <= cnt_q;
        end else if (svc_clear) begin
            cnt_q <= '0;
        end else if (run && tick) begin
            cnt_q <= cnt_q + `CNT_W'(1);
        end
    end

    // held until the system reset that it requests
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            fired_q <= 1'b0;
        end else if (svc_fault || ovf_evt) begin
            fired_q <= 1'b1;
        end
    end

    assign internal_reset = fired_q;

    ////////////////////////////////////////////////////////////////////////////
    // sticky interrupt status, cleared by a read, set wins over the clear
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            status_q <= '0;
        end else if (irq_evt) begin
            status_q <= 1'b1;
        end else if (rd && (wb_adr_i == `OFF_IRQ_STATUS)) begin
            status_q <= '0;
        end
    end

    assign interval_irq = |(status_q & mask_q);

    ////////////////////////////////////////////////////////////////////////////
    // checks
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (reset);

    property p_clear;
        svc_wr && key_ok && first_done_q && win_open && !fired_q |=> cnt_q == '0 && !fired_q;
    endproperty
    a_clear: assert property (p_clear) else $error("key write in open window did not clear");

    property p_closed;
        svc_wr && key_ok && first_done_q && !win_open |=> internal_reset [*2];
    endproperty
    a_closed: assert property (p_closed) else $error("key write in closed window gave no reset");

    property p_first;
        svc_wr && key_ok && !first_done_q && !fired_q |=> cnt_q == '0 && !internal_reset && first_done_q;
    endproperty
    a_first: assert property (p_first) else $error("first service write not honoured");

    property p_win50;
        opt_q.standby_run_opt && opt_q.window_period_sel_hi == 1'b0 && opt_q.window_period_sel_lo
            |-> win.close_end + win.close_end == win.overflow_at;
    endproperty
    a_win50: assert property (p_win50) else $error("50 percent window limit wrong");

    property p_win75;
        opt_q.standby_run_opt && opt_q.window_period_sel_hi && !opt_q.window_period_sel_lo
            |-> win.close_end + win.close_end + win.close_end + win.close_end == win.overflow_at
            && win.close_end != '0;
    endproperty
    a_win75: assert property (p_win75) else $error("75 percent window limit wrong");

    property p_stby;
        !opt_q.standby_run_opt |-> win.close_end == '0 && win_open;
    endproperty
    a_stby: assert property (p_stby) else $error("window not fully open with standby run off");

    property p_ovf9;
        {opt_q.overflow_sel_2, opt_q.overflow_sel_1, opt_q.overflow_sel_0} == 3'h3
            |-> win.overflow_at == 18'h00400 && win.irq_at == 18'h00301;
    endproperty
    a_ovf9: assert property (p_ovf9) else $error("overflow or interval limit wrong for code 3");

    property p_irq;
        irq_evt |=> status_q[0] ##0 (interval_irq == mask_q[0]);
    endproperty
    a_irq: assert property (p_irq) else $error("interval event did not set the flag");

    property p_noirq;
        !opt_q.interval_irq_opt && !status_q[0] |=> !status_q[0];
    endproperty
    a_noirq: assert property (p_noirq) else $error("interval flag set while option off");

    property p_keep;
        irq_evt && !svc_wr |=> cnt_q == $past(cnt_q) + `CNT_W'(1);
    endproperty
    a_keep: assert property (p_keep) else $error("counter stalled at interval interrupt");

    property p_ovf;
        run && cnt_q == win.overflow_at && !svc_clear |=> internal_reset;
    endproperty
    a_ovf: assert property (p_ovf) else $error("overflow gave no reset");

    property p_badkey;
        svc_wr && !key_ok |=> internal_reset;
    endproperty
    a_badkey: assert property (p_badkey) else $error("wrong key gave no reset");

    property p_rdsvc;
        rd && wb_adr_i == `OFF_SERVICE |=> wb_ack_o && wb_dat_o[7:0] != `SERVICE_KEY
            && wb_dat_o[7:0] == (opt_q.count_enable ? `SERVICE_RD_ON : `SERVICE_RD_OFF);
    endproperty
    a_rdsvc: assert property (p_rdsvc) else $error("service read value wrong");

    property p_win100;
        opt_q.standby_run_opt && opt_q.window_period_sel_hi && opt_q.window_period_sel_lo
            |-> win.close_end == '0 && win_open;
    endproperty
    a_win100: assert property (p_win100) else $error("100 percent window not fully open");

    property p_win00;
        opt_q.standby_run_opt && !opt_q.window_period_sel_hi && !opt_q.window_period_sel_lo
            |-> win.close_end == '0;
    endproperty
    a_win00: assert property (p_win00) else $error("prohibited window code not treated as full");

    property p_ovf6;
        {opt_q.overflow_sel_2, opt_q.overflow_sel_1, opt_q.overflow_sel_0} == 3'h0
            |-> win.overflow_at == 18'h00080 && win.irq_at == 18'h00061;
    endproperty
    a_ovf6: assert property (p_ovf6) else $error("overflow or interval limit wrong for code 0");

    property p_ovf11;
        {opt_q.overflow_sel_2, opt_q.overflow_sel_1, opt_q.overflow_sel_0} == 3'h4
            |-> win.overflow_at == 18'h01000 && win.irq_at == 18'h00c01;
    endproperty
    a_ovf11: assert property (p_ovf11) else $error("overflow or interval limit wrong for code 4");

    property p_ovf16;
        {opt_q.overflow_sel_2, opt_q.overflow_sel_1, opt_q.overflow_sel_0} == 3'h7
            |-> win.overflow_at == 18'h20000 && win.irq_at == 18'h18001;
    endproperty
    a_ovf16: assert property (p_ovf16) else $error("overflow or interval limit wrong for code 7");

    property p_run;
        opt_q.count_enable && !internal_reset && tick && !svc_wr |=> cnt_q == $past(cnt_q) + `CNT_W'(1);
    endproperty
    a_run: assert property (p_run) else $error("counter missed a low-speed half period");

    property p_hold;
        internal_reset |=> internal_reset;
    endproperty
    a_hold: assert property (p_hold) else $error("internal reset dropped before system reset");

    property p_frozen;
        internal_reset |=> $stable(cnt_q);
    endproperty
    a_frozen: assert property (p_frozen) else $error("counter moved after internal reset");

    property p_rdclr;
        rd && wb_adr_i == `OFF_IRQ_STATUS && !irq_evt |=> status_q == '0;
    endproperty
    a_rdclr: assert property (p_rdclr) else $error("status read did not clear the flag");

    c_service: cover property (svc_clear && first_done_q);
    c_irq:     cover property (irq_evt ##[1:20] interval_irq);
    c_ovf:     cover property (ovf_evt);
    c_first:   cover property (svc_clear && !first_done_q);
    c_closed:  cover property (svc_fault && key_ok && first_done_q);
endmodule

// ==== windowed_watchdog_interval_irq_bench.sv ====
// self-checking bench for the windowed watchdog over classic wishbone
`timescale 1ns/1ps
`include "wdog_consts.svh"
module windowed_watchdog_interval_irq_bench
    import wdog_pkg::*;
;
    logic                clk_sys;
    logic                reset;
    logic                cyc;
    logic                stb;
    logic                we;
    logic [`ADDR_W-1:0]  adr;
    logic [3:0]          sel;
    logic [31:0]         wdat;
    logic [31:0]         rdat;
    logic                ack;
    logic                interval_irq;
    logic                internal_reset;
    logic [31:0]         d;
    int                  n_mismatch;
    int                  checks;
    int                  n;

    wdog_top dut (
        .clk_sys        (clk_sys),
        .reset          (reset),
        .wb_cyc_i       (cyc),
        .wb_stb_i       (stb),
        .wb_we_i        (we),
        .wb_adr_i       (adr),
        .wb_sel_i       (sel),
        .wb_dat_i       (wdat),
        .wb_dat_o       (rdat),
        .wb_ack_o       (ack),
        .interval_irq   (interval_irq),
        .internal_reset (internal_reset)
    );

    always #20 clk_sys = ~clk_sys;

    ////////////////////////////////////////////////////////////////////////
    task automatic end_of_test();
        $display("comparisons %0d, mismatches %0d", checks, n_mismatch);
        if (n_mismatch == 0 && checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
        checks++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("Error at %0t: %s seen %h expected %h", $time, what, seen, exp);
        end
    endtask

    // one classic cycle, held until ack is sampled high
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] rd);
        int k;
        @(posedge clk_sys);
        cyc  <= 1'b1;
        stb  <= 1'b1;
        we   <= w;
        adr  <= a;
        wdat <= wd;
        sel  <= 4'hf;
        k = 0;
        do begin
            @(posedge clk_sys);
            k++;
        end while (ack !== 1'b1 && k < 20);
        rd = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
        we  <= 1'b0;
        if (k >= 20) begin
            check(32'h0, 32'h1, "ack timeout");
            end_of_test();
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        logic [31:0] dummy;
        xfer(1'b1, a, {24'h0, v}, dummy);
    endtask

    task automatic rd(input logic [7:0] a, output logic [31:0] v);
        xfer(1'b0, a, 32'h0, v);
    endtask

    task automatic reset_dut();
        @(posedge clk_sys);
        reset <= 1'b1;
        repeat (5) @(posedge clk_sys);
        reset <= 1'b0;
    endtask

    // option byte with counting enabled
    function automatic opt_t mk_opt(logic irq, logic [1:0] win, logic [2:0] ovf, logic stby);
        opt_t o;
        o.interval_irq_opt     = irq;
        o.window_period_sel_hi = win[1];
        o.window_period_sel_lo = win[0];
        o.count_enable         = 1'b1;
        {o.overflow_sel_2, o.overflow_sel_1, o.overflow_sel_0} = ovf;
        o.standby_run_opt      = stby;
        return o;
    endfunction

    ////////////////////////////////////////////////////////////////////////
    initial begin
        clk_sys = 1'b0;
        reset = 1'b1;
        cyc = 1'b0;
        stb = 1'b0;
        we = 1'b0;
        adr = '0;
        sel = 4'h0;
        wdat = '0;
        n_mismatch = 0;
        checks = 0;
        repeat (5) @(posedge clk_sys);
        reset <= 1'b0;

        // reset values, unmapped place, read-back and bad key
        rd(`OFF_SERVICE, d);
        check(d, {24'h0, `SERVICE_RD_ON}, "service read enabled");
        rd(`OFF_OPTION, d);
        check(d, {24'h0, `OPTION_RESET}, "option reset value");
        wr(8'h20, 8'h55);
        rd(8'h20, d);
        check(d, 32'h0, "unmapped read");
        wr(`OFF_OPTION, 8'h00);
        rd(`OFF_SERVICE, d);
        check(d, {24'h0, `SERVICE_RD_OFF}, "service read disabled");
        check({31'h0, internal_reset}, 32'h0, "no fault yet");
        wr(`OFF_SERVICE, 8'h55);
        @(posedge clk_sys);
        check({31'h0, internal_reset}, 32'h1, "wrong key fault");
        $display("test bad_key done");

        // standby option clear forces full window
        reset_dut();
        wr(`OFF_OPTION, mk_opt(1'b0, 2'b01, 3'b000, 1'b0));
        repeat (2000) @(posedge clk_sys);
        rd(`OFF_COUNT, d);
        check({31'h0, d != 0}, 32'h1, "counter running");
        wr(`OFF_SERVICE, `SERVICE_KEY);
        rd(`OFF_COUNT, d);
        check(d, 32'h0, "first service clears");
        wr(`OFF_SERVICE, `SERVICE_KEY);
        @(posedge clk_sys);
        check({31'h0, internal_reset}, 32'h0, "full window key");
        rd(`OFF_STATE, d);
        check({31'h0, d[1]}, 32'h1, "window open at once");
        $display("test full_window done");

        // 50 percent window: second key in closed part faults
        reset_dut();
        wr(`OFF_OPTION, mk_opt(1'b0, 2'b01, 3'b000, 1'b1));
        wr(`OFF_SERVICE, `SERVICE_KEY);
        @(posedge clk_sys);
        check({31'h0, internal_reset}, 32'h0, "first key in closed part");
        rd(`OFF_STATE, d);
        check({30'h0, d[1:0]}, 32'h1, "closed after clear, first done");
        wr(`OFF_SERVICE, `SERVICE_KEY);
        @(posedge clk_sys);
        check({31'h0, internal_reset}, 32'h1, "closed window key");
        $display("test closed_window done");

        // 75 percent window with interval interrupt
        reset_dut();
        wr(`OFF_OPTION, mk_opt(1'b1, 2'b10, 3'b000, 1'b1));
        wr(`OFF_IRQ_MASK, 8'h01);
        wr(`OFF_SERVICE, `SERVICE_KEY);
        n = 0;
        // service only after the flag, never in the prohibited interval
        while (interval_irq !== 1'b1 && n < 90000) begin
            @(posedge clk_sys);
            n++;
        end
        if (n >= 90000) begin
            check(32'h0, 32'h1, "interval timeout");
            end_of_test();
        end
        rd(`OFF_COUNT, d);
        check(d, 32'h61, "interval point");
        rd(`OFF_STATE, d);
        check({31'h0, d[1]}, 32'h1, "open at interval");
        wr(`OFF_IRQ_MASK, 8'h00);
        check({31'h0, interval_irq}, 32'h0, "masked");
        wr(`OFF_IRQ_MASK, 8'h01);
        check({31'h0, interval_irq}, 32'h1, "unmasked");
        rd(`OFF_IRQ_STATUS, d);
        check(d, 32'h1, "flag set");
        check({31'h0, interval_irq}, 32'h0, "read clears");
        rd(`OFF_IRQ_STATUS, d);
        check(d, 32'h0, "flag cleared");
        repeat (900) @(posedge clk_sys);
        rd(`OFF_COUNT, d);
        check({31'h0, d > 32'h61}, 32'h1, "keeps counting");
        wr(`OFF_SERVICE, `SERVICE_KEY);
        @(posedge clk_sys);
        check({31'h0, internal_reset}, 32'h0, "open window key");
        rd(`OFF_COUNT, d);
        check(d, 32'h0, "restart from zero");
        $display("test interval done");

        end_of_test();
    end
endmodule
